// ===== logic/gptu_pkg.sv
`default_nettype none
package gptu_pkg;
  // register index inside one block, byte address bits [3:0]
  localparam logic [3:0] REG_CTL_A   = 4'h0;
  localparam logic [3:0] REG_CTL_B   = 4'h1;
  localparam logic [3:0] REG_LOAD_A  = 4'h2;
  localparam logic [3:0] REG_LOAD_B  = 4'h3;
  localparam logic [3:0] REG_MATCH_A = 4'h4;
  localparam logic [3:0] REG_MATCH_B = 4'h5;
  localparam logic [3:0] REG_PRE_A   = 4'h6;
  localparam logic [3:0] REG_PRE_B   = 4'h7;
  localparam logic [3:0] REG_VAL_A   = 4'h8;
  localparam logic [3:0] REG_VAL_B   = 4'h9;
  localparam logic [3:0] REG_STAT    = 4'ha;
  localparam logic [3:0] REG_CAP_A   = 4'hb;
  localparam logic [3:0] REG_CAP_B   = 4'hc;
  // control field positions
  localparam int CTL_EN    = 3;
  localparam int CTL_INV   = 4;
  localparam int CTL_STALL = 5;
  localparam int CTL_ADC   = 6;
  localparam int CTL_CAT   = 7;
  localparam int CTL_W     = 8;
  // status field positions, two bits each (half a, half b)
  localparam int ST_TO  = 0;
  localparam int ST_CAP = 2;
  localparam int ST_PWM = 4;
  localparam int ST_W   = 6;
  // reset values
  localparam logic [7:0]  CTL_RST  = 8'h00;
  localparam logic [15:0] LOAD_RST = 16'hffff;
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [7:0]  PRE_RST  = 8'h00;
  typedef enum logic [2:0] {
    M_OFF     = 3'b000,
    M_ONESHOT = 3'b001,
    M_PERIOD  = 3'b010,
    M_ECOUNT  = 3'b011,
    M_ETIME   = 3'b100,
    M_PWM     = 3'b101,
    M_RTC     = 3'b110
  } gptu_mode_t;
endpackage : gptu_pkg
`default_nettype wire

// ===== logic/gptu_top.sv
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module gptu_top #(
  parameter int NBLK = 3,
  parameter int CW   = 16,
  parameter int PW   = 8
) (
  input  wire logic              CLK_I,
  input  wire logic              RST_I,
  input  wire logic [7:0]        ADDR_I,
  input  wire logic [31:0]       WDATA_I,
  input  wire logic              WR_I,
  input  wire logic              RD_I,
  output logic      [31:0]       RDATA_O,
  input  wire logic              HALT_I,
  input  wire logic [2*NBLK-1:0] CAPTURE_COMPARE_PWM_PIN_I,
  output logic      [2*NBLK-1:0] CAPTURE_COMPARE_PWM_PIN_O,
  output logic      [2*NBLK-1:0] CAPTURE_COMPARE_PWM_PIN_OE_O,
  output logic      [NBLK-1:0]   ADC_TRIG_O
);
  localparam int NT = 2 * NBLK;
  logic [gptu_pkg::CTL_W-1:0] ctl_reg [NT], ctl_next [NT];
  logic [CW-1:0] load_reg [NT], load_next [NT];
  logic [CW-1:0] match_reg [NT], match_next [NT];
  logic [CW-1:0] cnt_reg [NT], cnt_next [NT];
  logic [CW-1:0] cap_reg [NT], cap_next [NT];
  logic [PW-1:0] pre_reg [NT], pre_next [NT];
  logic [PW-1:0] pcnt_reg [NT], pcnt_next [NT];
  logic [gptu_pkg::ST_W-1:0] stat_reg [NBLK], stat_next [NBLK];
  logic [NT-1:0]   prev_reg, prev_next, pwm_reg, pwm_next;
  logic [NT-1:0]   ev_to, ev_cap, ev_pw, tick, run, edg;
  logic [NBLK-1:0] adc_reg, adc_next;
  logic [31:0]     rdata_reg, rdata_next;

  function automatic logic sel(input logic [7:0] a, input int b,
                               input logic [3:0] r);
    sel = (a[7:4] == 4'(b)) && (a[3:0] == r);
  endfunction : sel

  // register writes, counting and flags for every half of every block
  always_comb begin
    logic [2*CW-1:0] c32, l32, m32;
    logic cat;
    gptu_pkg::gptu_mode_t md;
    c32 = '0;
    l32 = '0;
    m32 = '0;
    cat = 1'b0;
    md  = gptu_pkg::M_OFF;
    ev_to  = '0;
    ev_cap = '0;
    ev_pw  = '0;
    tick   = '0;
    run    = '0;
    edg    = '0;
    prev_next = CAPTURE_COMPARE_PWM_PIN_I;
    pwm_next  = pwm_reg;
    rdata_next = 32'h0000_0000;
    for (int i = 0; i < NT; i++) begin
      ctl_next[i]   = ctl_reg[i];
      load_next[i]  = load_reg[i];
      match_next[i] = match_reg[i];
      pre_next[i]   = pre_reg[i];
      cnt_next[i]   = cnt_reg[i];
      cap_next[i]   = cap_reg[i];
      pcnt_next[i]  = pcnt_reg[i];
    end
    // software writes; enabling a half restarts it from its load value
    for (int i = 0; i < NT; i++) begin
      if (WR_I && sel(ADDR_I, i / 2, gptu_pkg::REG_CTL_A + 4'(i % 2))) begin
        ctl_next[i] = WDATA_I[gptu_pkg::CTL_W-1:0];
        if (WDATA_I[gptu_pkg::CTL_EN] && !ctl_reg[i][gptu_pkg::CTL_EN]) begin
          cnt_next[i]  = load_reg[i];
          pcnt_next[i] = pre_reg[i];
          // joined halves restart together as one 32-bit count
          if ((i % 2 == 0) && WDATA_I[gptu_pkg::CTL_CAT])
            cnt_next[i | 1] = load_reg[i | 1];
        end
      end
      if (WR_I && sel(ADDR_I, i / 2, gptu_pkg::REG_LOAD_A + 4'(i % 2)))
        load_next[i] = WDATA_I[CW-1:0];
      if (WR_I && sel(ADDR_I, i / 2, gptu_pkg::REG_MATCH_A + 4'(i % 2)))
        match_next[i] = WDATA_I[CW-1:0];
      if (WR_I && sel(ADDR_I, i / 2, gptu_pkg::REG_PRE_A + 4'(i % 2)))
        pre_next[i] = WDATA_I[PW-1:0];
    end
    // timing engine per half
    for (int i = 0; i < NT; i++) begin
      cat = ctl_reg[i & ~1][gptu_pkg::CTL_CAT];
      md  = gptu_pkg::gptu_mode_t'(ctl_reg[i][2:0]);
      run[i] = ctl_reg[i][gptu_pkg::CTL_EN] &&
               !(ctl_reg[i][gptu_pkg::CTL_STALL] && HALT_I);
      edg[i]  = CAPTURE_COMPARE_PWM_PIN_I[i] && !prev_reg[i];
      tick[i] = run[i] && (pcnt_reg[i] == '0);
      if (run[i])
        pcnt_next[i] = tick[i] ? pre_reg[i] : pcnt_reg[i] - 1'b1;
      if (cat && (i % 2 == 0)) begin
        // joined halves: a holds the low word, b the high word
        c32 = {cnt_reg[i+1], cnt_reg[i]};
        l32 = {load_reg[i+1], load_reg[i]};
        m32 = {match_reg[i+1], match_reg[i]};
        if (tick[i]) begin
          case (md)
            gptu_pkg::M_RTC: begin
              c32 = c32 + 1'b1;
              ev_to[i] = (c32 == m32);
            end
            gptu_pkg::M_ONESHOT, gptu_pkg::M_PERIOD: begin
              if (c32 == '0) begin
                ev_to[i] = 1'b1;
                if (md == gptu_pkg::M_PERIOD)
                  c32 = l32;
                else
                  ctl_next[i][gptu_pkg::CTL_EN] = 1'b0;
              end else begin
                c32 = c32 - 1'b1;
              end
            end
            default: ;
          endcase
          {cnt_next[i+1], cnt_next[i]} = c32;
        end
      end else if (!cat) begin
        case (md)
          gptu_pkg::M_ONESHOT, gptu_pkg::M_PERIOD: begin
            if (tick[i]) begin
              if (cnt_reg[i] == '0) begin
                ev_to[i] = 1'b1;
                if (md == gptu_pkg::M_PERIOD)
                  cnt_next[i] = load_reg[i];
                else
                  ctl_next[i][gptu_pkg::CTL_EN] = 1'b0;
              end else begin
                cnt_next[i] = cnt_reg[i] - 1'b1;
              end
            end
          end
          gptu_pkg::M_ECOUNT: begin
            if (run[i] && edg[i]) begin
              if (cnt_reg[i] == '0) begin
                ev_cap[i]   = 1'b1;
                cnt_next[i] = load_reg[i];
              end else begin
                cnt_next[i] = cnt_reg[i] - 1'b1;
              end
            end
          end
          gptu_pkg::M_ETIME: begin
            if (tick[i])
              cnt_next[i] = (cnt_reg[i] == '0) ? load_reg[i]
                                               : cnt_reg[i] - 1'b1;
            if (run[i] && edg[i]) begin
              ev_cap[i]   = 1'b1;
              cap_next[i] = cnt_reg[i];
            end
          end
          gptu_pkg::M_PWM: begin
            if (tick[i]) begin
              if (cnt_reg[i] == '0) begin
                ev_pw[i]    = 1'b1;
                cnt_next[i] = load_reg[i];
              end else begin
                cnt_next[i] = cnt_reg[i] - 1'b1;
              end
            end
            pwm_next[i] = (cnt_reg[i] > match_reg[i]) ^
                          ctl_reg[i][gptu_pkg::CTL_INV];
          end
          default: ;
        endcase
      end
    end
    // sticky flags: write one clears, a new event wins over the clear
    for (int b = 0; b < NBLK; b++) begin
      stat_next[b] = stat_reg[b];
      if (WR_I && sel(ADDR_I, b, gptu_pkg::REG_STAT))
        stat_next[b] = stat_reg[b] & ~WDATA_I[gptu_pkg::ST_W-1:0];
      stat_next[b] = stat_next[b] | {ev_pw[2*b+1], ev_pw[2*b],
                                     ev_cap[2*b+1], ev_cap[2*b],
                                     ev_to[2*b+1], ev_to[2*b]};
      adc_next[b] = (ev_to[2*b] && ctl_reg[2*b][gptu_pkg::CTL_ADC]) ||
                    (ev_to[2*b+1] && ctl_reg[2*b+1][gptu_pkg::CTL_ADC]);
    end
    // read data, unmapped addresses read zero
    for (int i = 0; i < NT; i++) begin
      if (RD_I && sel(ADDR_I, i / 2, gptu_pkg::REG_CTL_A + 4'(i % 2)))
        rdata_next = 32'(ctl_reg[i]);
      if (RD_I && sel(ADDR_I, i / 2, gptu_pkg::REG_LOAD_A + 4'(i % 2)))
        rdata_next = 32'(load_reg[i]);
      if (RD_I && sel(ADDR_I, i / 2, gptu_pkg::REG_MATCH_A + 4'(i % 2)))
        rdata_next = 32'(match_reg[i]);
      if (RD_I && sel(ADDR_I, i / 2, gptu_pkg::REG_PRE_A + 4'(i % 2)))
        rdata_next = 32'(pre_reg[i]);
      if (RD_I && sel(ADDR_I, i / 2, gptu_pkg::REG_VAL_A + 4'(i % 2)))
        rdata_next = 32'(cnt_reg[i]);
      if (RD_I && sel(ADDR_I, i / 2, gptu_pkg::REG_CAP_A + 4'(i % 2)))
        rdata_next = 32'(cap_reg[i]);
      if (RD_I && (i % 2 == 0) && sel(ADDR_I, i / 2, gptu_pkg::REG_STAT))
        rdata_next = 32'(stat_reg[i/2]);
    end
  end

  // state registers
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      for (int i = 0; i < NT; i++) begin
        ctl_reg[i]   <= gptu_pkg::CTL_RST;
        load_reg[i]  <= gptu_pkg::LOAD_RST;
        match_reg[i] <= gptu_pkg::CNT_RST;
        cnt_reg[i]   <= gptu_pkg::CNT_RST;
        cap_reg[i]   <= gptu_pkg::CNT_RST;
        pre_reg[i]   <= gptu_pkg::PRE_RST;
        pcnt_reg[i]  <= gptu_pkg::PRE_RST;
      end
      for (int b = 0; b < NBLK; b++)
        stat_reg[b] <= '0;
      prev_reg  <= '0;
      pwm_reg   <= '0;
      adc_reg   <= '0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ctl_reg   <= ctl_next;
      load_reg  <= load_next;
      match_reg <= match_next;
      cnt_reg   <= cnt_next;
      cap_reg   <= cap_next;
      pre_reg   <= pre_next;
      pcnt_reg  <= pcnt_next;
      stat_reg  <= stat_next;
      prev_reg  <= prev_next;
      pwm_reg   <= pwm_next;
      adc_reg   <= adc_next;
      rdata_reg <= rdata_next;
    end
  end

  // pin drive: enabled only for split halves in pwm mode
  always_comb begin
    for (int i = 0; i < NT; i++)
      CAPTURE_COMPARE_PWM_PIN_OE_O[i] =
        !ctl_reg[i & ~1][gptu_pkg::CTL_CAT] &&
        (ctl_reg[i][2:0] == gptu_pkg::M_PWM);
  end
  assign CAPTURE_COMPARE_PWM_PIN_O = pwm_reg;
  assign ADC_TRIG_O                = adc_reg;
  assign RDATA_O                   = rdata_reg;

  // checks on block 0
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  wire split0 = !ctl_reg[0][gptu_pkg::CTL_CAT];
  wire [2:0] md0 = ctl_reg[0][2:0];
  wire [2*CW-1:0] c32_0 = {cnt_reg[1], cnt_reg[0]};

  a_read_value: assert property (RD_I && ADDR_I == 8'h08 |=>
    RDATA_O == 32'($past(cnt_reg[0]))) else $error("value read wrong");
  a_oneshot_stop: assert property (split0 && md0 == gptu_pkg::M_ONESHOT &&
    tick[0] && cnt_reg[0] == '0 && !WR_I |=> !ctl_reg[0][gptu_pkg::CTL_EN]
    && stat_reg[0][gptu_pkg::ST_TO]) else $error("one-shot did not stop");
  a_period_reload: assert property (split0 && md0 == gptu_pkg::M_PERIOD &&
    tick[0] && cnt_reg[0] == '0 |=> cnt_reg[0] == $past(load_reg[0]))
    else $error("periodic did not reload");
  a_halt_stall: assert property (ctl_reg[0][gptu_pkg::CTL_STALL] && HALT_I &&
    !WR_I |=> $stable(cnt_reg[0]) && $stable(pcnt_reg[0]))
    else $error("counter moved while halted");
  a_flag_sticky: assert property (stat_reg[0][0] && !(WR_I &&
    ADDR_I == 8'h0a) |=> stat_reg[0][0]) else $error("flag lost");
  a_pwm_invert: assert property (split0 && md0 == gptu_pkg::M_PWM |=>
    CAPTURE_COMPARE_PWM_PIN_O[0] == ($past(cnt_reg[0] > match_reg[0]) ^
    $past(ctl_reg[0][gptu_pkg::CTL_INV]))) else $error("pwm level wrong");
  a_adc_cause: assert property (ADC_TRIG_O[0] |->
    $past(ev_to[0] || ev_to[1])) else $error("stray converter trigger");
  a_edge_count: assert property (split0 && md0 == gptu_pkg::M_ECOUNT &&
    run[0] && edg[0] && cnt_reg[0] != '0 && !WR_I |=>
    cnt_reg[0] == $past(cnt_reg[0]) - 1'b1) else $error("edge not counted");
  a_edge_time: assert property (split0 && md0 == gptu_pkg::M_ETIME &&
    run[0] && edg[0] |=> cap_reg[0] == $past(cnt_reg[0]))
    else $error("edge time not captured");
  a_rtc_count: assert property (!split0 && md0 == gptu_pkg::M_RTC &&
    tick[0] && !WR_I |=> c32_0 == $past(c32_0) + 1'b1)
    else $error("clock did not advance");
  c_oneshot: cover property (ev_to[0] && md0 == gptu_pkg::M_ONESHOT);
  c_pwm_end: cover property (ev_pw[0]);
  c_capture: cover property (ev_cap[0] || ev_cap[1]);
  c_rtc:     cover property (!split0 && ev_to[0]);
endmodule : gptu_top
`default_nettype wire

// ===== verif/gptu_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// external event source and pin load for the six timer pins
module gptu_pin_model (
  input  wire logic       clk_i,
  input  wire logic [5:0] pin_i,
  input  wire logic [5:0] oe_i,
  output logic      [5:0] pin_o
);
  initial pin_o = 6'h00;
  // rising edges, each high and low for one cycle
  task automatic pulse(input int idx, input int cnt);
    repeat (cnt) begin
      @(posedge clk_i);
      pin_o[idx] <= 1'b1;
      @(posedge clk_i);
      pin_o[idx] <= 1'b0;
    end
    @(posedge clk_i);
  endtask : pulse
  // the load only sees a level while the pin is driven
  task automatic measure(input int idx, input int cyc, output int hi);
    hi = 0;
    repeat (cyc) begin
      @(posedge clk_i);
      #1;
      if (oe_i[idx] === 1'b1 && pin_i[idx] === 1'b1) hi++;
    end
  endtask : measure
endmodule : gptu_pin_model
`default_nettype wire

// ===== verif/general_purpose_timer_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module general_purpose_timer_unit_tb;
  logic        clk   = 1'b0;
  logic        rst   = 1'b1;
  logic [7:0]  addr  = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic        halt  = 1'b0;
  logic [31:0] rdata;
  logic [5:0]  pin_in;
  logic [5:0]  pin_out;
  logic [5:0]  pin_oe;
  logic [2:0]  trig;
  int          err_total   = 0;
  int          comparisons = 0;
  logic [31:0] d;
  logic [31:0] e;
  int          ld;
  int          pr;
  int          n;
  int          hi;
  gptu_top dut (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .HALT_I(halt),
    .CAPTURE_COMPARE_PWM_PIN_I(pin_in), .CAPTURE_COMPARE_PWM_PIN_O(pin_out),
    .CAPTURE_COMPARE_PWM_PIN_OE_O(pin_oe), .ADC_TRIG_O(trig));
  gptu_pin_model pins (.clk_i(clk), .pin_i(pin_out), .oe_i(pin_oe),
    .pin_o(pin_in));
  initial forever #2 clk = ~clk;
  // one write cycle, then an idle edge
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // read data is taken in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // cycles until the next converter trigger of one block
  task automatic wait_trig(input int bk, output int cyc);
    cyc = 0;
    do begin
      @(posedge clk);
      #1;
      cyc++;
    end while (trig[bk] !== 1'b1 && cyc < 400);
  endtask : wait_trig
  // expected period of a split counter
  function automatic int period(input int load, input int pre);
    return (load + 1) * (pre + 1);
  endfunction : period
  task automatic stop_test;
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    stop_test;
  end
  // main sequence
  initial begin
    void'($urandom(46138));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // reset values, unmapped and read-only places
    rd_reg(8'h00, d);
    chk(d, 32'h0);
    rd_reg(8'h23, d);
    chk(d, 32'hffff);
    rd_reg(8'h0d, d);
    chk(d, 32'h0);
    wr_reg(8'h32, 32'h5);
    rd_reg(8'h32, d);
    chk(d, 32'h0);
    wr_reg(8'h18, 32'h1234);
    rd_reg(8'h18, d);
    chk(d, 32'h0);
    // periodic with prescaler and converter trigger, every block
    for (int b = 0; b < 3; b++) begin
      ld = $urandom % 6 + 1;
      pr = $urandom % 3;
      wr_reg({b[3:0], 4'h2}, ld);
      wr_reg({b[3:0], 4'h6}, pr);
      wr_reg({b[3:0], 4'h0}, 32'h4a);
      wait_trig(b, n);
      wait_trig(b, n);
      chk(n, period(ld, pr));
      rd_reg({b[3:0], 4'ha}, d); chk(d & 32'h1, 32'h1);
      wr_reg({b[3:0], 4'h0}, 32'h0);
      wr_reg({b[3:0], 4'ha}, 32'h3f);
      rd_reg({b[3:0], 4'ha}, d); chk(d, 32'h0);
    end
    // one-shot clears its own enable
    wr_reg(8'h13, 32'h3);
    wr_reg(8'h11, 32'h09);
    repeat (12) @(posedge clk);
    rd_reg(8'h11, d); chk(d, 32'h01);
    rd_reg(8'h1a, d); chk(d & 32'h2, 32'h2);
    // edge count: fourth edge from load 3 sets the flag
    wr_reg(8'h22, 32'h3);
    wr_reg(8'h20, 32'h0b);
    pins.pulse(4, 3);
    rd_reg(8'h2a, d); chk(d & 32'h4, 32'h0);
    pins.pulse(4, 1);
    rd_reg(8'h2a, d); chk(d & 32'h4, 32'h4);
    // edge time records a count within the load range
    wr_reg(8'h20, 32'h0);
    wr_reg(8'h2a, 32'h3f);
    wr_reg(8'h22, 32'hff);
    wr_reg(8'h20, 32'h0c);
    pins.pulse(4, 1);
    rd_reg(8'h2a, d); chk(d & 32'h4, 32'h4);
    rd_reg(8'h2b, d); chk(d[31:8], 24'h0);
    // pwm on half b, plain and inverted, one period of ten cycles
    wr_reg(8'h03, 32'h9);
    wr_reg(8'h05, 32'h2);
    for (int inv = 0; inv < 2; inv++) begin
      wr_reg(8'h01, inv ? 32'h1d : 32'h0d);
      repeat (4) @(posedge clk);
      pins.measure(1, 10, hi);
      e = inv ? 32'd3 : 32'd7;
      chk(hi, e);
      rd_reg(8'h0a, d); chk(d & 32'h20, 32'h20);
    end
    // stall while the debug halt flag is high
    wr_reg(8'h02, 32'hff);
    wr_reg(8'h00, 32'h2a);
    halt <= 1'b1;
    rd_reg(8'h08, d);
    chk(d, 32'hff);
    rd_reg(8'h08, e);
    chk(e, d);
    @(posedge clk);
    halt <= 1'b0;
    // let at least one prescaled tick pass before looking again
    repeat (4) @(posedge clk);
    rd_reg(8'h08, e);
    chk(e == d, 1'b0);
    // joined halves borrow across sixteen bits
    wr_reg(8'h00, 32'h0);
    wr_reg(8'h01, 32'h0);
    wr_reg(8'h06, 32'h0);
    wr_reg(8'h02, 32'h0);
    wr_reg(8'h03, 32'h1);
    wr_reg(8'h00, 32'h89);
    rd_reg(8'h09, d); chk(d, 32'h0);
    rd_reg(8'h08, d); chk(d[15:8], 8'hff);
    // real-time clock counts up from zero and flags the match value
    wr_reg(8'h00, 32'h0);
    wr_reg(8'h03, 32'h0);
    wr_reg(8'h04, 32'h5);
    wr_reg(8'h05, 32'h0);
    wr_reg(8'h0a, 32'h3f);
    wr_reg(8'h00, 32'hce);
    wait_trig(0, n);
    chk(n, 32'd5);
    rd_reg(8'h0a, d);
    chk(d & 32'h1, 32'h1);
    stop_test;
  end
endmodule : general_purpose_timer_unit_tb
`default_nettype wire
